// ==== hdl/mmn_pkg.sv ====
// Overview of operation
// [RULE1] copy_any_to_any takes 12-bit source and destination, covering all of 000h..FFFh.
// [RULE2] copy_any_to_any may use the accumulator as its source or its destination.
// [RULE3] copy_any_to_any never writes program_counter_low or the three stack_top registers.
// [RULE4] Copy is two words; source read first cycle, destination written end of second.
// [RULE5] load_bank_literal puts literal low nibble in bank_pointer; upper nibble stays zero.
// [RULE6] load_acc_literal loads the literal into the accumulator, one cycle, flags untouched.
// [RULE7] store_acc writes the accumulator to the addressed file location, flags untouched.
// [RULE8] Access bit 0 selects the access bank; 1 uses bank_pointer for the bank.
// [RULE9] Access bit 0, extended set on, address up to 95: indexed literal offset.
// [RULE10] mul_acc_literal puts unsigned accumulator times literal into the product pair.
// [RULE11] mul_acc_reg multiplies accumulator by the file register; operands stay unchanged.
// [RULE12] product_high takes the upper product byte, product_low the lower one.
// [RULE13] Multiplies change no status flag; no zero, carry or overflow indication.
// [RULE14] negate_reg writes the two's complement back and updates all five flags.
// [RULE15] The product is visible to the very next instruction.
`default_nettype none

package mmn_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 8;

    // Opcode fields
    localparam logic [3:0] OPC_COPY_SRC = 4'hC;
    localparam logic [7:0] OPC_LOAD_BANK = 8'h01;
    localparam logic [7:0] OPC_LOAD_ACC = 8'h0E;
    localparam logic [7:0] OPC_MUL_LIT = 8'h0D;
    localparam logic [6:0] OPC_MUL_REG = 7'h01;
    localparam logic [6:0] OPC_NEGATE = 7'h36;
    localparam logic [6:0] OPC_STORE_ACC = 7'h37;

    // Field positions in the instruction word
    localparam int unsigned ACCESS_BIT = 8;

    // Addressing
    localparam logic [7:0] ACCESS_LOW_LAST = 8'h5F;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

    // Special function register locations in the data space
    localparam logic [11:0] ACC_ADDR = 12'hFE8;
    localparam logic [11:0] PC_LOW_ADDR = 12'hFF9;
    localparam logic [11:0] TOS_UPPER_ADDR = 12'hFFF;
    localparam logic [11:0] TOS_HIGH_ADDR = 12'hFFE;
    localparam logic [11:0] TOS_LOW_ADDR = 12'hFFD;

    // Reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] BANK_RST = 8'h00;
    localparam logic [15:0] PROD_RST = 16'h0000;

    typedef struct packed {
        logic msb_set;
        logic signed_wrap;
        logic result_null;
        logic half_wrap;
        logic unsigned_wrap;
    } mmn_status_s;

    typedef struct packed {
        logic we;
        logic [11:0] addr;
        logic [7:0] data;
    } mmn_wr_s;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_COPY_SRC,
        OP_COPY_DST,
        OP_LOAD_BANK,
        OP_LOAD_ACC,
        OP_STORE_ACC,
        OP_MUL_LIT,
        OP_MUL_REG,
        OP_NEGATE
    } mmn_op_e;

    typedef enum logic {
        ST_IDLE,
        ST_COPY_WAIT
    } mmn_state_e;

endpackage : mmn_pkg

`default_nettype wire

// ==== hdl/mmn_addr_map.sv ====
`default_nettype none

module mmn_addr_map (
    // File operand
    input wire logic [7:0] file_sel,
    input wire logic bank_sel,
    // Addressing state
    input wire logic [3:0] bank_pointer,
    input wire logic ext_en,
    input wire logic [11:0] index_base,
    // Full data address
    output logic [11:0] addr
);
    import mmn_pkg::*;

    always_comb begin
        if (bank_sel) begin
            addr = {bank_pointer, file_sel}; // RULE8
        end else if (ext_en && file_sel <= ACCESS_LOW_LAST) begin
            addr = 12'(index_base + {4'h0, file_sel}); // RULE9
        end else if (file_sel <= ACCESS_LOW_LAST) begin
            addr = {4'h0, file_sel}; // RULE8
        end else begin
            addr = {ACCESS_HIGH_BANK, file_sel}; // RULE8
        end
    end

endmodule : mmn_addr_map

`default_nettype wire

// ==== hdl/mmn_exec.sv ====
`default_nettype none

module mmn_exec (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Instruction stream, one word per cycle while valid
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    // Addressing mode
    input wire logic ext_set_en,
    input wire logic [11:0] index_base,
    // Data memory
    output logic [11:0] mem_raddr,
    input wire logic [7:0] mem_rdata,
    output var mmn_pkg::mmn_wr_s mem_wr,
    // Core state
    output logic [7:0] acc,
    output logic [7:0] bank_pointer,
    output logic [7:0] product_high,
    output logic [7:0] product_low,
    output var mmn_pkg::mmn_status_s status,
    output logic copy_pending,
    output logic copy_refused
);
    import mmn_pkg::*;

    logic [1:0] rst_sync_reg;
    logic rst_n;

    // Asynchronous assert, synchronous release
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    mmn_state_e state_reg, state_next;
    logic [7:0] acc_reg, acc_next;
    logic [7:0] bank_reg, bank_next;
    logic [15:0] prod_reg, prod_next;
    mmn_status_s status_reg, status_next;
    logic [7:0] copy_data_reg, copy_data_next;
    mmn_wr_s wr_reg, wr_next;
    logic refused_reg, refused_next;

    mmn_op_e op;
    logic [11:0] file_addr;
    logic [7:0] rd_data;
    logic [7:0] neg_val;
    logic [15:0] mul_lit_val;
    logic [15:0] mul_reg_val;
    logic dst_protected;
    logic write_en;
    logic [11:0] write_addr;
    logic [7:0] write_val;

    always_comb begin
        op = OP_NONE;
        if (instr_valid) begin
            if (state_reg == ST_COPY_WAIT) begin
                op = OP_COPY_DST;
            end else if (instr_word[15:12] == OPC_COPY_SRC) begin
                op = OP_COPY_SRC;
            end else if (instr_word[15:8] == OPC_LOAD_BANK) begin
                op = OP_LOAD_BANK;
            end else if (instr_word[15:8] == OPC_LOAD_ACC) begin
                op = OP_LOAD_ACC;
            end else if (instr_word[15:8] == OPC_MUL_LIT) begin
                op = OP_MUL_LIT;
            end else if (instr_word[15:9] == OPC_MUL_REG) begin
                op = OP_MUL_REG;
            end else if (instr_word[15:9] == OPC_NEGATE) begin
                op = OP_NEGATE;
            end else if (instr_word[15:9] == OPC_STORE_ACC) begin
                op = OP_STORE_ACC;
            end
        end
    end

    mmn_addr_map u_addr_map (
        .file_sel(instr_word[7:0]),
        .bank_sel(instr_word[ACCESS_BIT]),
        .bank_pointer(bank_reg[3:0]),
        .ext_en(ext_set_en),
        .index_base(index_base),
        .addr(file_addr)
    );

    // Copy source uses the full 12-bit field of the first word
    assign mem_raddr = (op == OP_COPY_SRC) ? instr_word[11:0] : file_addr; // RULE1

    // Accumulator is read in place; a pending write is forwarded
    always_comb begin
        if (mem_raddr == ACC_ADDR) begin
            rd_data = acc_reg; // RULE2
        end else if (wr_reg.we && wr_reg.addr == mem_raddr) begin
            rd_data = wr_reg.data;
        end else begin
            rd_data = mem_rdata;
        end
    end

    assign neg_val = 8'(8'h00 - rd_data); // RULE14
    assign mul_lit_val = 16'({8'h00, acc_reg} * {8'h00, instr_word[7:0]}); // RULE10
    assign mul_reg_val = 16'({8'h00, acc_reg} * {8'h00, rd_data}); // RULE11
    assign dst_protected = (instr_word[11:0] == PC_LOW_ADDR)
        || (instr_word[11:0] == TOS_UPPER_ADDR)
        || (instr_word[11:0] == TOS_HIGH_ADDR) || (instr_word[11:0] == TOS_LOW_ADDR);

    always_comb begin
        state_next = state_reg;
        acc_next = acc_reg;
        bank_next = bank_reg;
        prod_next = prod_reg;
        status_next = status_reg;
        copy_data_next = copy_data_reg;
        wr_next = '0;
        refused_next = 1'b0;
        write_en = 1'b0;
        write_addr = file_addr;
        write_val = 8'h00;
        case (op)
            OP_COPY_SRC: begin
                copy_data_next = rd_data; // RULE4
                state_next = ST_COPY_WAIT;
            end
            OP_COPY_DST: begin
                state_next = ST_IDLE;
                write_addr = instr_word[11:0]; // RULE1
                if (dst_protected) begin
                    refused_next = 1'b1; // RULE3
                end else begin
                    write_en = 1'b1; // RULE4
                    write_val = copy_data_reg;
                end
            end
            OP_LOAD_BANK: begin
                bank_next = {4'h0, instr_word[3:0]}; // RULE5
            end
            OP_LOAD_ACC: begin
                acc_next = instr_word[7:0]; // RULE6
            end
            OP_STORE_ACC: begin
                write_en = 1'b1; // RULE7
                write_val = acc_reg;
            end
            OP_MUL_LIT: begin
                prod_next = mul_lit_val; // RULE15
            end
            OP_MUL_REG: begin
                prod_next = mul_reg_val; // RULE15
            end
            OP_NEGATE: begin
                write_en = 1'b1;
                write_val = neg_val;
                status_next.msb_set = neg_val[7]; // RULE14
                status_next.result_null = (neg_val == 8'h00);
                status_next.signed_wrap = (rd_data == 8'h80);
                status_next.unsigned_wrap = (rd_data == 8'h00);
                status_next.half_wrap = (rd_data[3:0] == 4'h0);
            end
            default: begin
            end
        endcase
        if (write_en) begin
            if (write_addr == ACC_ADDR) begin
                acc_next = write_val; // RULE2
            end else begin
                wr_next.we = 1'b1;
                wr_next.addr = write_addr;
                wr_next.data = write_val;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            acc_reg <= ACC_RST;
            bank_reg <= BANK_RST;
            prod_reg <= PROD_RST;
            status_reg <= '0;
            copy_data_reg <= 8'h00;
            wr_reg <= '0;
            refused_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            acc_reg <= acc_next;
            bank_reg <= bank_next;
            prod_reg <= prod_next;
            status_reg <= status_next;
            copy_data_reg <= copy_data_next;
            wr_reg <= wr_next;
            refused_reg <= refused_next;
        end
    end

    assign mem_wr = wr_reg;
    assign acc = acc_reg;
    assign bank_pointer = bank_reg;
    assign product_high = prod_reg[15:8]; // RULE12
    assign product_low = prod_reg[7:0]; // RULE12
    assign status = status_reg;
    assign copy_pending = (state_reg == ST_COPY_WAIT);
    assign copy_refused = refused_reg;

    sequence copy_src_s;
        op == OP_COPY_SRC;
    endsequence

    sequence copy_dst_ok_s;
        op == OP_COPY_DST && !dst_protected && instr_word[11:0] != ACC_ADDR;
    endsequence

    copy_first_word_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE4
        copy_src_s |=> copy_pending && copy_data_reg == $past(rd_data) && !mem_wr.we)
        else $error("copy source not captured");

    // Second word may follow after any stall; the pending state already ties it to its source
    copy_dest_write_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE1
        copy_dst_ok_s
        |=> mem_wr.we && mem_wr.addr == $past(instr_word[11:0])
            && mem_wr.data == $past(copy_data_reg) && !copy_pending)
        else $error("copy destination write wrong");

    copy_protect_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE3
        op == OP_COPY_DST && dst_protected |=> !mem_wr.we && copy_refused)
        else $error("protected copy destination written");

    copy_acc_dest_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE2
        op == OP_COPY_DST && instr_word[11:0] == ACC_ADDR
        |=> acc == $past(copy_data_reg) && !mem_wr.we)
        else $error("copy to accumulator failed");

    bank_load_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE5
        op == OP_LOAD_BANK |=> bank_pointer == {4'h0, $past(instr_word[3:0])}
            && $stable(status))
        else $error("bank pointer load wrong");

    bank_upper_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE5
        bank_pointer[7:4] == 4'h0)
        else $error("bank pointer upper nibble set");

    acc_load_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE6
        op == OP_LOAD_ACC |=> acc == $past(instr_word[7:0]) && $stable(status))
        else $error("accumulator literal load wrong");

    store_acc_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE7
        op == OP_STORE_ACC && file_addr != ACC_ADDR
        |=> mem_wr.we && mem_wr.data == $past(acc) && mem_wr.addr == $past(file_addr)
            && $stable(status))
        else $error("store accumulator wrong");

    bank_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE8
        instr_word[ACCESS_BIT] |-> file_addr == {bank_reg[3:0], instr_word[7:0]})
        else $error("banked address wrong");

    indexed_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE9
        !instr_word[ACCESS_BIT] && ext_set_en && instr_word[7:0] <= ACCESS_LOW_LAST
        |-> file_addr == 12'(index_base + {4'h0, instr_word[7:0]}))
        else $error("indexed address wrong");

    mul_lit_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE10
        op == OP_MUL_LIT |=> {product_high, product_low}
            == 16'({8'h00, $past(acc)} * {8'h00, $past(instr_word[7:0])}) && $stable(acc))
        else $error("literal product wrong");

    mul_reg_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE11
        op == OP_MUL_REG |=> {product_high, product_low}
            == 16'({8'h00, $past(acc)} * {8'h00, $past(rd_data)})
            && $stable(acc) && !mem_wr.we)
        else $error("register product wrong");

    mul_flags_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE13
        op == OP_MUL_LIT || op == OP_MUL_REG |=> $stable(status))
        else $error("multiply changed status");

    negate_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE14
        op == OP_NEGATE && file_addr != ACC_ADDR
        |=> mem_wr.we && mem_wr.data == 8'(8'h00 - $past(rd_data))
            && status.result_null == (mem_wr.data == 8'h00)
            && status.msb_set == mem_wr.data[7]
            && status.signed_wrap == ($past(rd_data) == 8'h80))
        else $error("negate result or flags wrong");

endmodule : mmn_exec

`default_nettype wire

// ==== tb/mmn_mem_model.sv ====
`default_nettype none

module mmn_mem_model (
    // Clock
    input wire logic core_clk,
    // Read port, combinational
    input wire logic [11:0] raddr,
    output logic [7:0] rdata,
    // Write port, applied at the edge after the strobe appears
    input wire mmn_pkg::mmn_wr_s wr
);
    timeunit 1ns;
    timeprecision 1ps;
    import mmn_pkg::*;

    logic [7:0] mem [0:4095];

    // Known filler so a stray read never settles by simulator choice
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'hA5;
        end
    end

    assign rdata = mem[raddr];

    always @(posedge core_clk) begin
        if (wr.we === 1'b1) begin
            mem[wr.addr] <= wr.data;
        end
    end
endmodule : mmn_mem_model

`default_nettype wire

// ==== tb/mmn_exec_tb_top.sv ====
`default_nettype none

`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); end end

module mmn_exec_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import mmn_pkg::*;

    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic instr_valid = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic ext_set_en = 1'b0;
    logic [11:0] index_base = 12'h300;
    logic [11:0] mem_raddr;
    logic [7:0] mem_rdata;
    mmn_wr_s mem_wr;
    logic [7:0] acc;
    logic [7:0] bank_pointer;
    logic [7:0] product_high;
    logic [7:0] product_low;
    mmn_status_s status;
    logic copy_pending;
    logic copy_refused;
    int error_cnt = 0;
    int comparisons = 0;

    always #5 core_clk = ~core_clk;

    mmn_exec u_mmn_exec (
        .core_clk(core_clk), .rstn(rstn), .instr_valid(instr_valid),
        .instr_word(instr_word), .ext_set_en(ext_set_en), .index_base(index_base),
        .mem_raddr(mem_raddr), .mem_rdata(mem_rdata), .mem_wr(mem_wr), .acc(acc),
        .bank_pointer(bank_pointer), .product_high(product_high),
        .product_low(product_low), .status(status), .copy_pending(copy_pending),
        .copy_refused(copy_refused)
    );

    mmn_mem_model u_mmn_mem_model (
        .core_clk(core_clk), .raddr(mem_raddr), .rdata(mem_rdata), .wr(mem_wr)
    );

    // One word taken at the next edge; valid stays up for back-to-back words
    task automatic issue(input logic [15:0] w);
        instr_valid = 1'b1;
        instr_word = w;
        @(posedge core_clk);
        #1;
    endtask : issue

    task automatic idle();
        instr_valid = 1'b0;
        @(posedge core_clk);
        #1;
    endtask : idle

    task automatic neg_case(input logic [7:0] f, input logic [7:0] v,
                            input logic [7:0] res, input logic [4:0] st);
        u_mmn_mem_model.mem[{4'h0, f}] = v;
        issue({OPC_NEGATE, 1'b0, f});
        `CHK(status, st)
        idle();
        `CHK(u_mmn_mem_model.mem[{4'h0, f}], res)
    endtask : neg_case

    task automatic t_negate();
        neg_case(8'h10, 8'h3A, 8'hC6, 5'h10);
        neg_case(8'h11, 8'h00, 8'h00, 5'h07);
        neg_case(8'h12, 8'h80, 8'h80, 5'h1A);
    endtask : t_negate

    // Literal loads and multiplies leave the flags from the last negate alone
    task automatic t_literals_mul();
        issue({OPC_LOAD_BANK, 8'h25});
        issue({OPC_LOAD_ACC, 8'hE2});
        `CHK(bank_pointer, 8'h05)
        issue({OPC_MUL_LIT, 8'hC4});
        `CHK(acc, 8'hE2)
        u_mmn_mem_model.mem[12'h020] = 8'hB5;
        issue({OPC_LOAD_ACC, 8'hC4});
        `CHK({product_high, product_low}, 16'hAD08)
        issue({OPC_MUL_REG, 1'b0, 8'h20});
        idle();
        `CHK({product_high, product_low}, 16'h8A94)
        `CHK(acc, 8'hC4)
        `CHK(u_mmn_mem_model.mem[12'h020], 8'hB5)
        `CHK(status, 5'h1A)
    endtask : t_literals_mul

    task automatic t_store();
        issue({OPC_LOAD_BANK, 8'h02});
        issue({OPC_STORE_ACC, 1'b1, 8'h10});
        issue({OPC_STORE_ACC, 1'b0, 8'h80});
        ext_set_en = 1'b1;
        issue({OPC_STORE_ACC, 1'b0, 8'h5F});
        issue({OPC_STORE_ACC, 1'b0, 8'h60});
        idle();
        ext_set_en = 1'b0;
        `CHK(u_mmn_mem_model.mem[12'h210], 8'hC4)
        `CHK(u_mmn_mem_model.mem[12'hF80], 8'hC4)
        `CHK(u_mmn_mem_model.mem[12'h35F], 8'hC4)
        `CHK(u_mmn_mem_model.mem[12'hF60], 8'hC4)
        `CHK(u_mmn_mem_model.mem[12'h05F], 8'hA5)
        `CHK(status, 5'h1A)
    endtask : t_store

    task automatic t_copy();
        logic [11:0] prot [4];
        prot = '{PC_LOW_ADDR, TOS_UPPER_ADDR, TOS_HIGH_ADDR, TOS_LOW_ADDR};
        u_mmn_mem_model.mem[12'h000] = 8'h33;
        issue({OPC_COPY_SRC, 12'h000});
        idle();
        `CHK(copy_pending, 1'b1)
        idle();
        issue(16'hFFFC);
        `CHK(copy_pending, 1'b0)
        idle();
        `CHK(u_mmn_mem_model.mem[12'hFFC], 8'h33)
        issue({OPC_COPY_SRC, ACC_ADDR});
        issue(16'hF400);
        issue({OPC_COPY_SRC, 12'hFFC});
        issue({4'hF, ACC_ADDR});
        idle();
        `CHK(u_mmn_mem_model.mem[12'h400], 8'hC4)
        `CHK(acc, 8'h33)
        for (int i = 0; i < 4; i++) begin
            u_mmn_mem_model.mem[prot[i]] = 8'h5A;
            issue({OPC_COPY_SRC, 12'h000});
            issue({4'hF, prot[i]});
            `CHK(copy_refused, 1'b1)
            idle();
            `CHK(u_mmn_mem_model.mem[prot[i]], 8'h5A)
        end
    endtask : t_copy

    task automatic summarize();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (6) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        t_negate();
        t_literals_mul();
        t_store();
        t_copy();
        summarize();
    end

    // The tests need well under a thousand cycles
    initial begin
        #50000;
        error_cnt++;
        summarize();
    end
endmodule : mmn_exec_tb_top

`default_nettype wire
